//--- rtl/pll_irq_pkg.sv
// Constants shared by the PLL lock interrupt and power mode block.
// Assumes an 8-bit register port and a single core clock domain.
package pll_irq_pkg;
    // Register offsets on the 8-bit port
    localparam logic [1:0] PLL_CONTROL_REG_OFS = 2'h0;
    localparam logic [1:0] PLL_BANDWIDTH_CTRL_REG_OFS = 2'h1;
    localparam logic [1:0] IRQ_STATUS_REG_OFS = 2'h2;
    localparam logic [1:0] IRQ_MASK_REG_OFS = 2'h3;
    // Control register fields
    localparam int CTRL_IRQ_ENABLE_BIT = 7;
    localparam int CTRL_EVENT_FLAG_BIT = 6;
    localparam int CTRL_POWER_ON_BIT = 5;
    localparam int CTRL_BASE_SEL_BIT = 4;
    // Bandwidth register fields
    localparam int BW_AUTO_BIT = 7;
    localparam int BW_LOCK_BIT = 6;
    // Status and mask fields
    localparam int STAT_GAINED_BIT = 0;
    localparam int STAT_LOST_BIT = 1;
    localparam int STAT_W = 2;
    // Values after reset
    localparam logic PLL_ON_RST = 1'b1;
    localparam logic BASE_SEL_RST = 1'b0;
    localparam logic AUTO_RST = 1'b0;
    localparam logic IRQ_EN_RST = 1'b0;
    localparam logic [STAT_W-1:0] MASK_RST = 2'h0;
endpackage

//--- rtl/pll_lock_irq_power_modes.sv
// PLL lock event flag, interrupt, stop-mode gating and break protection.
// Assumes all inputs synchronous to core_clk_i; crystal clock = core clock.
`timescale 1ns/1ns
module pll_lock_irq_power_modes (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic lock_detect_i,
    input wire logic vco_tick_i,
    input wire logic stop_i,
    input wire logic osc_run_in_stop_option_i,
    input wire logic break_i,
    input wire logic break_clear_enable_i,
    output logic clock_module_irq_o,
    output logic crystal_clock_en_o,
    output logic module_output_clock_en_o,
    output logic out_src_vco_o,
    output logic pll_power_on_o
);
    import pll_irq_pkg::*;

    // All block state but the reset synchroniser in one record
    // One record keeps reset and update in a single place, at the cost
    // of every field being rewritten each cycle by the next-state copy.
    // Fields are grouped by function, mixing what software sees and what stays inside.
    typedef struct packed {
        // Control and bandwidth bits
        logic irq_en;
        logic pll_on;
        logic base_sel;
        logic auto_bw;
        // Event tracking
        logic event_flag;
        logic lock;
        // Stop edge detect, sticky status and its mask
        logic stop_d;
        logic [STAT_W-1:0] stat;
        logic [STAT_W-1:0] mask;
        // Bus read data, clock pulse state and the irq line
        logic [7:0] rdata;
        logic div_x;
        logic div_v;
        logic out_en;
        logic irq;
    } state_t;

    state_t cur_ff; // Registered state
    state_t nxt_cur; // Next state
    logic rst_s1_ff; // Reset sync first stage
    logic rst_s2_ff; // Reset sync second stage

    // Reset release through two flops
    // Assertion is immediate, release is clocked, so no flop of the block
    // leaves reset on a half-settled edge.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    logic osc_off; // Oscillator stopped by stop mode
    logic pll_live; // PLL powered and not stopped
    logic lock_now; // Qualified lock indicator
    logic lock_chg; // Lock edge this cycle
    logic clr_ok; // Status clears permitted
    logic [STAT_W-1:0] ev_set; // Event set vector

    // Combinational helpers
    // Stop and break qualifiers are decoded once here so that the
    // next-state process and the checks see the same terms.
    // All of them come straight from inputs and registered state.
    always_comb begin
        // stop removes PLL; option keeps osc
        osc_off = stop_i && !osc_run_in_stop_option_i;
        pll_live = cur_ff.pll_on && !stop_i;
        // lock follows detector, wait has no say
        lock_now = cur_ff.auto_bw && pll_live && lock_detect_i;
        lock_chg = cur_ff.auto_bw && (lock_now != cur_ff.lock);
        clr_ok = !break_i || break_clear_enable_i;
        ev_set = '0;
        ev_set[STAT_GAINED_BIT] = lock_chg && lock_now;
        ev_set[STAT_LOST_BIT] = lock_chg && !lock_now;
    end

    // Next state
    // Order matters: bus writes and reads first, then hardware events,
    // so that an event in the same cycle as a clear wins.
    // Manual mode and stop entry are applied last and override both.
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.stop_d = stop_i;
        nxt_cur.lock = lock_now;
        nxt_cur.rdata = 8'h00;
        // Register writes
        if (wr_i) begin
            case (addr_i)
                PLL_CONTROL_REG_OFS: begin
                    nxt_cur.irq_en = wdata_i[CTRL_IRQ_ENABLE_BIT];
                    nxt_cur.pll_on = wdata_i[CTRL_POWER_ON_BIT];
                    // select taken without checking lock
                    // Select needs the PLL already powered
                    nxt_cur.base_sel = wdata_i[CTRL_BASE_SEL_BIT] && cur_ff.pll_on;
                end
                PLL_BANDWIDTH_CTRL_REG_OFS: begin
                    // Lock bit is read-only; write ignored
                    nxt_cur.auto_bw = wdata_i[BW_AUTO_BIT];
                end
                IRQ_STATUS_REG_OFS: begin
                    // write one clears, held in break unless clear enabled
                    if (clr_ok) begin
                        nxt_cur.stat = cur_ff.stat & ~wdata_i[STAT_W-1:0];
                    end
                end
                IRQ_MASK_REG_OFS: begin
                    nxt_cur.mask = wdata_i[STAT_W-1:0];
                end
                default: begin
                    nxt_cur.mask = cur_ff.mask;
                end
            endcase
        end
        // Register reads, data one cycle later
        if (rd_i) begin
            case (addr_i)
                PLL_CONTROL_REG_OFS: begin
                    nxt_cur.rdata[CTRL_IRQ_ENABLE_BIT] = cur_ff.irq_en;
                    // flag reads 0 in manual mode
                    nxt_cur.rdata[CTRL_EVENT_FLAG_BIT] = cur_ff.event_flag && cur_ff.auto_bw;
                    nxt_cur.rdata[CTRL_POWER_ON_BIT] = cur_ff.pll_on;
                    nxt_cur.rdata[CTRL_BASE_SEL_BIT] = cur_ff.base_sel;
                    // reading clears flag unless break protects
                    if (clr_ok) begin
                        nxt_cur.event_flag = 1'b0;
                    end
                end
                PLL_BANDWIDTH_CTRL_REG_OFS: begin
                    nxt_cur.rdata[BW_AUTO_BIT] = cur_ff.auto_bw;
                    // lock visible only in automatic mode
                    // Masked by mode too, since lock lags the mode bit by one cycle
                    nxt_cur.rdata[BW_LOCK_BIT] = cur_ff.lock && cur_ff.auto_bw;
                end
                IRQ_STATUS_REG_OFS: begin
                    nxt_cur.rdata[STAT_W-1:0] = cur_ff.stat;
                end
                IRQ_MASK_REG_OFS: begin
                    nxt_cur.rdata[STAT_W-1:0] = cur_ff.mask;
                end
                default: begin
                    nxt_cur.rdata = 8'h00;
                end
            endcase
        end
        // flag sets regardless of enable; set beats clear
        if (lock_chg) begin
            nxt_cur.event_flag = 1'b1;
        end
        // Sticky status, set beats clear
        nxt_cur.stat = nxt_cur.stat | ev_set;
        // manual mode holds flag at zero
        if (!cur_ff.auto_bw) begin
            nxt_cur.event_flag = 1'b0;
        end
        // Cleared on entry whatever the source, which is harmless when
        // the crystal already drives the output.
        // stop entry drops VCO select, stays clear
        if (stop_i && !cur_ff.stop_d) begin
            nxt_cur.base_sel = 1'b0;
        end
        // Half-rate dividers for both sources
        // The VCO divider only moves on ticks, so its output is sparse;
        // limitation: pulse spacing follows the tick rate, not the core clock.
        nxt_cur.div_x = osc_off ? 1'b0 : !cur_ff.div_x;
        if (vco_tick_i && pll_live) begin
            nxt_cur.div_v = !cur_ff.div_v;
        end
        // output enable forced low with osc stopped
        if (osc_off) begin
            nxt_cur.out_en = 1'b0;
        end else if (cur_ff.base_sel) begin
            nxt_cur.out_en = vco_tick_i && pll_live && cur_ff.div_v;
        end else begin
            nxt_cur.out_en = cur_ff.div_x;
        end
        // Uses the next status so a new event raises the line one cycle sooner.
        // Stop without the option forces the line low regardless of status.
        // enable, mode and stop gate the irq
        nxt_cur.irq = cur_ff.irq_en && cur_ff.auto_bw && !osc_off
            && (|(nxt_cur.stat & cur_ff.mask));
    end

    // State register
    // Reset values come from the package; everything else starts at zero,
    // so irq and VCO select stay low until software programs the block, read data until a read.
    always_ff @(posedge core_clk_i or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            cur_ff <= '0;
            cur_ff.irq_en <= IRQ_EN_RST;
            cur_ff.pll_on <= PLL_ON_RST;
            cur_ff.base_sel <= BASE_SEL_RST;
            cur_ff.auto_bw <= AUTO_RST;
            cur_ff.mask <= MASK_RST;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs
    // Power and crystal enables are combinational so that stop acts at once;
    // the rest are registered.
    assign rdata_o = cur_ff.rdata;
    assign clock_module_irq_o = cur_ff.irq;
    assign crystal_clock_en_o = !osc_off;
    assign module_output_clock_en_o = cur_ff.out_en;
    assign out_src_vco_o = cur_ff.base_sel;
    assign pll_power_on_o = pll_live;

    // Checks
    // Assertions sample on the core clock and sleep while reset is held,
    // so the reset copy from the synchroniser is the disable condition.
    // Most look one cycle ahead, since most outputs are registered.
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_s2_ff);

    // change sets flag
    // Lock change sets flag next cycle
    lock_event_a: assert property (lock_chg |=> cur_ff.event_flag || !cur_ff.auto_bw)
        else $error("lock change did not set flag");
    // enable gates irq
    // Disabled irq stays low
    irq_gate_a: assert property (!cur_ff.irq_en && !$past(cur_ff.irq_en) |-> !clock_module_irq_o)
        else $error("irq without enable");
    // flag without enable
    // Flag sets with enable off too
    flag_noen_a: assert property (lock_chg && !cur_ff.irq_en |=> cur_ff.event_flag)
        else $error("flag missed with enable off");
    // manual mode quiet
    // Manual mode: no irq, flag clear
    manual_quiet_a: assert property (!cur_ff.auto_bw |=> !cur_ff.event_flag && !clock_module_irq_o)
        else $error("manual mode flag or irq");
    // unlocked select accepted
    // VCO select accepted while unlocked
    sel_unlocked_a: assert property (wr_i && addr_i == PLL_CONTROL_REG_OFS
        && wdata_i[CTRL_BASE_SEL_BIT] && cur_ff.pll_on && !stop_i |=> out_src_vco_o)
        else $error("select refused");
    // unpowered select refused
    // Select needs the PLL already powered
    sel_power_a: assert property (wr_i && addr_i == PLL_CONTROL_REG_OFS
        && !cur_ff.pll_on |=> !out_src_vco_o)
        else $error("select taken unpowered");
    // stop gates outputs
    // Stop without option gates output clock enable and irq
    stop_gate_a: assert property (stop_i && !osc_run_in_stop_option_i
        |=> !module_output_clock_en_o && !clock_module_irq_o)
        else $error("outputs alive in stop");
    // divider parks low
    // Crystal half-rate divider parks low while the oscillator is off
    div_park_a: assert property (osc_off |=> !cur_ff.div_x)
        else $error("divider ran in stop");
    // dead VCO silent
    // Unpowered VCO source gives no output pulses
    vco_gate_a: assert property (out_src_vco_o && !pll_power_on_o |=> !module_output_clock_en_o)
        else $error("output from dead vco");
    // stop clears select
    // Stop entry clears select, stays clear for the next two cycles
    stop_sel_a: assert property ($rose(stop_i) |=> !out_src_vco_o [*2])
        else $error("select kept in stop");
    // select stays clear
    // Only a software write may set the select again
    sel_stays_a: assert property (cur_ff.stop_d && !out_src_vco_o
        && !(wr_i && addr_i == PLL_CONTROL_REG_OFS) |=> !out_src_vco_o)
        else $error("select set itself");
    // stop power split
    // Stop always turns off PLL power, osc follows option
    stop_pll_a: assert property (stop_i |-> !pll_power_on_o
        && crystal_clock_en_o == osc_run_in_stop_option_i)
        else $error("stop power wrong");
    // wait leaves clocks
    // Outside stop the oscillator runs and PLL power follows its bit
    wait_osc_a: assert property (!stop_i |-> crystal_clock_en_o)
        else $error("oscillator off outside stop");
    wait_pll_a: assert property (!stop_i |-> pll_power_on_o == cur_ff.pll_on)
        else $error("pll power changed outside stop");
    // break keeps flag
    // Protected break read keeps flag
    break_keep_a: assert property (break_i && !break_clear_enable_i && cur_ff.event_flag
        && cur_ff.auto_bw && !(wr_i && addr_i == PLL_BANDWIDTH_CTRL_REG_OFS) |=> cur_ff.event_flag)
        else $error("flag lost in break");
    // flag is sticky
    // Flag holds until a read clears it; manual mode is checked above
    flag_hold_a: assert property (cur_ff.event_flag && cur_ff.auto_bw
        && !(rd_i && addr_i == PLL_CONTROL_REG_OFS) |=> cur_ff.event_flag)
        else $error("flag dropped by itself");
    flag_read_zero_a: assert property (rd_i && addr_i == PLL_CONTROL_REG_OFS && !cur_ff.auto_bw
        |=> !rdata_o[CTRL_EVENT_FLAG_BIT])
        else $error("flag read in manual mode");
    // irq needs enable
    // Interrupt only after enable and automatic mode
    irq_source_a: assert property (clock_module_irq_o |-> $past(cur_ff.irq_en) && $past(cur_ff.auto_bw))
        else $error("irq without enable or auto");
    // lock needs auto
    // Lock only under automatic mode
    lock_auto_a: assert property (cur_ff.lock |-> $past(cur_ff.auto_bw))
        else $error("lock outside auto");
    lock_read_zero_a: assert property (rd_i && addr_i == PLL_BANDWIDTH_CTRL_REG_OFS && !cur_ff.auto_bw
        |=> !rdata_o[BW_LOCK_BIT])
        else $error("lock read in manual mode");

    // status per bit
    // Set on event, sticky, cleared only by a permitted write of one.
    // A clear meeting an event in one cycle loses, so the clear check skips it.
    generate
        for (genvar b = 0; b < STAT_W; b++) begin : g_stat
            stat_set_a: assert property (ev_set[b] |=> cur_ff.stat[b])
                else $error("status bit not set");
            stat_hold_a: assert property (cur_ff.stat[b]
                && !(wr_i && addr_i == IRQ_STATUS_REG_OFS && wdata_i[b] && clr_ok) |=> cur_ff.stat[b])
                else $error("status bit dropped");
            stat_clear_a: assert property (wr_i && addr_i == IRQ_STATUS_REG_OFS && wdata_i[b]
                && clr_ok && !ev_set[b] |=> !cur_ff.stat[b])
                else $error("status clear lost");
        end
    endgenerate

    // Main scenarios; the bench reaches all but lock_lost_c
    lock_gain_c: cover property (ev_set[STAT_GAINED_BIT] ##[1:3] clock_module_irq_o);
    stop_vco_c: cover property (out_src_vco_o ##1 $rose(stop_i) ##1 !out_src_vco_o);
    break_read_c: cover property (break_i && rd_i && cur_ff.event_flag ##1 cur_ff.event_flag);
    lock_lost_c: cover property (ev_set[STAT_LOST_BIT] ##1 clock_module_irq_o);
    opt_stop_c: cover property (stop_i && osc_run_in_stop_option_i && crystal_clock_en_o);
endmodule

//--- test/pll_lock_model.sv
// Behavioural PLL seen from the clock block: lock detector and VCO ticks.
// Assumes the bench steers lock through lock_want_i; power comes from the block.
`timescale 1ns/1ns
module pll_lock_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic power_on_i,
    input wire logic lock_want_i,
    output logic lock_detect_o,
    output logic vco_tick_o
);
    logic [1:0] tick_cnt_ff; // VCO runs at a third of core rate

    // lock at frequency
    // No lock unless the loop is powered
    assign lock_detect_o = power_on_i & lock_want_i;

    // runs only while powered
    // Ticks only while powered, so stop really silences the VCO
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_ff <= 2'h0;
        end else if (power_on_i) begin
            tick_cnt_ff <= (tick_cnt_ff == 2'h2) ? 2'h0 : tick_cnt_ff + 2'h1;
        end
    end
    assign vco_tick_o = power_on_i & (tick_cnt_ff == 2'h2);
endmodule

//--- test/tb.sv
// Register-level bench of the PLL lock interrupt and power mode block.
// Assumes one core clock; the bench plays software, stop and break control.
`timescale 1ns/1ns
module tb;
    import pll_irq_pkg::*;
    logic core_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, rv;
    logic stop_i = 1'b0, opt_i = 1'b0, brk_i = 1'b0, bce_i = 1'b0, want = 1'b0;
    logic lock_w, tick_w, irq_o, xtal_en_o, out_en_o, src_o, pwr_o;
    int miscompares = 0, total_checks = 0, cycles = 0;
    logic [3:0] n;

    pll_lock_irq_power_modes i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lock_detect_i(lock_w),
        .vco_tick_i(tick_w), .stop_i(stop_i), .osc_run_in_stop_option_i(opt_i), .break_i(brk_i),
        .break_clear_enable_i(bce_i), .clock_module_irq_o(irq_o), .crystal_clock_en_o(xtal_en_o),
        .module_output_clock_en_o(out_en_o), .out_src_vco_o(src_o), .pll_power_on_o(pwr_o));
    pll_lock_model i_pll (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .power_on_i(pwr_o),
        .lock_want_i(want), .lock_detect_o(lock_w), .vco_tick_o(tick_w));

    // 100 MHz core clock
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    // Hang guard, far above the roughly 150 cycles needed
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles >= 3000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk_i);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk_i);
        rd_i <= 1'b1; addr_i <= a;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(what, rdata_o, exp);
    endtask
    // Output clock enables seen over k cycles
    task automatic count_out(input int k);
        n = 4'h0;
        repeat (k) begin
            cyc(1);
            n += {3'h0, out_en_o};
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        cyc(3);
        rd(PLL_CONTROL_REG_OFS, 8'h20, "ctrl reset");
        rd(PLL_BANDWIDTH_CTRL_REG_OFS, 8'h00, "bw reset");
        rd(IRQ_MASK_REG_OFS, 8'h00, "mask reset");
        $display("test reset done");
        want <= 1'b1; cyc(4);
        rd(PLL_BANDWIDTH_CTRL_REG_OFS, 8'h00, "manual lock");
        rd(PLL_CONTROL_REG_OFS, 8'h20, "manual flag");
        want <= 1'b0; cyc(4);
        chk("manual irq", irq_o, 8'h00);
        $display("test manual done");
        wr(IRQ_MASK_REG_OFS, 8'h03);
        wr(PLL_CONTROL_REG_OFS, 8'hA0);
        wr(PLL_BANDWIDTH_CTRL_REG_OFS, 8'h80);
        want <= 1'b1; cyc(4);
        chk("gain irq", irq_o, 8'h01);
        rd(PLL_BANDWIDTH_CTRL_REG_OFS, 8'hC0, "lock bit");
        rd(IRQ_STATUS_REG_OFS, 8'h01, "gain status");
        rd(PLL_CONTROL_REG_OFS, 8'hE0, "flag set");
        rd(PLL_CONTROL_REG_OFS, 8'hA0, "flag read clear");
        wr(IRQ_STATUS_REG_OFS, 8'h01); cyc(2);
        chk("cleared irq", irq_o, 8'h00);
        wr(PLL_CONTROL_REG_OFS, 8'h20);
        want <= 1'b0; cyc(4);
        chk("disabled irq", irq_o, 8'h00);
        rd(IRQ_STATUS_REG_OFS, 8'h02, "lost status");
        rd(PLL_CONTROL_REG_OFS, 8'h60, "flag no enable");
        wr(PLL_CONTROL_REG_OFS, 8'hA0); cyc(2);
        chk("enabled irq", irq_o, 8'h01);
        wr(PLL_CONTROL_REG_OFS, 8'h20);
        $display("test events done");
        want <= 1'b1; cyc(4);
        brk_i <= 1'b1;
        rd(PLL_CONTROL_REG_OFS, 8'h60, "break read 1");
        rd(PLL_CONTROL_REG_OFS, 8'h60, "break read 2");
        wr(IRQ_STATUS_REG_OFS, 8'h03);
        rd(IRQ_STATUS_REG_OFS, 8'h03, "break protect");
        bce_i <= 1'b1;
        wr(IRQ_STATUS_REG_OFS, 8'h03);
        brk_i <= 1'b0; bce_i <= 1'b0;
        rd(IRQ_STATUS_REG_OFS, 8'h00, "break clear kept");
        rd(PLL_CONTROL_REG_OFS, 8'h60, "flag after break");
        $display("test break done");
        // select VCO while unlocked, must be accepted
        want <= 1'b0; cyc(4);
        wr(PLL_CONTROL_REG_OFS, 8'hB0);
        chk("vco unlocked", src_o, 8'h01);
        rd(PLL_CONTROL_REG_OFS, 8'hF0, "ctrl vco");
        chk("irq before stop", irq_o, 8'h01);
        count_out(12);
        chk("vco out", n, 8'h02);
        stop_i <= 1'b1; cyc(2);
        chk("stop pll", pwr_o, 8'h00);
        chk("stop xtal", xtal_en_o, 8'h00);
        chk("stop irq", irq_o, 8'h00);
        chk("stop src", src_o, 8'h00);
        count_out(8);
        chk("stop out", n, 8'h00);
        stop_i <= 1'b0; cyc(2);
        chk("after src", src_o, 8'h00);
        rd(PLL_CONTROL_REG_OFS, 8'hA0, "after ctrl");
        count_out(8);
        chk("after out", n, 8'h04);
        opt_i <= 1'b1; stop_i <= 1'b1; cyc(2);
        chk("opt xtal", xtal_en_o, 8'h01);
        chk("opt pll", pwr_o, 8'h00);
        stop_i <= 1'b0; cyc(2);
        $display("test stop done");
        report_and_stop();
    end
endmodule
